// ===== hdl/pm_pkg.sv
// What this block does
// - unused gpio pads in deep sleep become inputs with a weak pulldown
// - pads in use keep software enabled pulls through deep sleep
// - in hibernate every digital pad floats with all pulls off
// - oscillator enable pin is an output driving high after power up
// - in hibernate oscillator enable floats and is pulled down
// - start-up logic enables the digital pad path without software help
// - analog switch is open after reset, closes only on software enable
// - start-up senses a pull-up on crystal output pad, freeing it
// - dedicated pads drive the antenna select switch, not reassigned
package pm_pkg;

  // pads handled here and their indices
  localparam int NPAD     = 4;
  localparam int NMODE    = 16;
  localparam int PAD_G8   = 0;
  localparam int PAD_G9   = 1;
  localparam int PAD_ANA  = 2;
  localparam int PAD_XTAL = 3;

  // register byte addresses
  localparam logic [31:0] PADCFG8_ADDR  = 32'h4402e0c0;
  localparam logic [31:0] PADCFG9_ADDR  = 32'h4402e0c4;
  localparam logic [31:0] PADCFGA_ADDR  = 32'h4402e0c8;
  localparam logic [31:0] PADCFGX_ADDR  = 32'h4402e0cc;
  localparam logic [31:0] CTRL_ADDR     = 32'h4402e100;
  localparam logic [31:0] GPIO_ADDR     = 32'h4402e104;
  localparam logic [31:0] STATUS_ADDR   = 32'h4402e108;

  // pad config fields
  localparam int          MODE_LSB      = 0;
  localparam int          PU_BIT        = 8;
  localparam int          PD_BIT        = 9;
  localparam logic [3:0]  MODE_GPIO     = 4'h0;

  // control fields and reset value
  localparam int          OSC_BIT       = 0;
  localparam int          ANA_BIT       = 1;
  localparam int          ANT_LSB       = 4;
  localparam logic [31:0] CTRL_RST      = 32'h00000001;

  // gpio data fields
  localparam int          GOUT_LSB      = 0;
  localparam int          GOE_LSB       = 8;

  // status fields
  localparam int          ST_DIG_BIT    = 0;
  localparam int          ST_EXT_BIT    = 1;
  localparam int          ST_DONE_BIT   = 2;
  localparam int          ST_IN_LSB     = 4;
  localparam int          ST_CONF_BIT   = 8;
  localparam int          ST_LOW_POWER_DEEP_SLEEP_BIT   = 9;
  localparam int          ST_HIB_BIT    = 10;

  // crystal pad sense window
  localparam int          CLK_MHZ       = 50;
  localparam int          SENSE_NS      = 1000;
  localparam int          SENSE_CYC     = (SENSE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_LOW_POWER_DEEP_SLEEP   = 2'b01,
    PM_HIB    = 2'b10
  } pm_pwr_e;

  typedef enum logic [1:0] {
    ST_SENSE = 2'b00,
    ST_BOOT  = 2'b01,
    ST_RUN   = 2'b10
  } pm_boot_e;

  typedef struct packed {
    logic       pd;
    logic       pu;
    logic [3:0] mode;
  } pm_padcfg_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
    logic wpd;
  } pm_pad_drv_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pm_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pm_apb_rsp_s;

endpackage : pm_pkg

// ===== hdl/pm_pad_cell.sv
module pm_pad_cell (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire pm_pkg::pm_padcfg_s        cfg,
  input  wire logic                      en,
  input  wire pm_pkg::pm_pwr_e           pwr,
  input  wire logic [pm_pkg::NMODE-1:0]  fn_out,
  input  wire logic [pm_pkg::NMODE-1:0]  fn_oe,
  input  wire logic                      pad_in,
  output pm_pkg::pm_pad_drv_s            drv,
  output logic                           din
);
  import pm_pkg::*;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    pm_pad_drv_s drv;
  } pm_cell_s;

  pm_cell_s state_r;
  pm_cell_s state_nxt;

  // pad drive per power state, input synchroniser
  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.sync1 = pad_in;
    state_nxt.sync2 = state_r.sync1;
    case (pwr)
      PM_ACTIVE:
      begin
        state_nxt.drv.out = en & fn_out[cfg.mode];
        state_nxt.drv.oe  = en & fn_oe[cfg.mode];
        state_nxt.drv.pu  = en & cfg.pu;
        state_nxt.drv.pd  = en & cfg.pd;
        state_nxt.drv.wpd = 1'b0;
      end
      PM_LOW_POWER_DEEP_SLEEP:
      begin
        if (en && (cfg.pu || cfg.pd))
        begin
          // in use: hold drive, keep chosen pulls
          state_nxt.drv.pu  = cfg.pu;
          state_nxt.drv.pd  = cfg.pd;
          state_nxt.drv.wpd = 1'b0;
        end
        else
        begin
          state_nxt.drv.out = 1'b0;
          state_nxt.drv.oe  = 1'b0;
          state_nxt.drv.pu  = 1'b0;
          state_nxt.drv.pd  = 1'b0;
          state_nxt.drv.wpd = en;
        end
      end
      default:
      begin
        state_nxt.drv = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign drv = state_r.drv;
  assign din = state_r.sync2;

endmodule : pm_pad_cell

// ===== hdl/pm_pad_mux.sv
module pm_pad_mux (
  input  wire logic                                    clock,
  input  wire logic                                    rst_n,
  input  wire pm_pkg::pm_apb_req_s                     apb_req,
  output pm_pkg::pm_apb_rsp_s                          apb_rsp,
  input  wire pm_pkg::pm_pwr_e                         pwr_mode,
  input  wire logic [pm_pkg::NPAD-1:0][pm_pkg::NMODE-1:0] fn_out,
  input  wire logic [pm_pkg::NPAD-1:0][pm_pkg::NMODE-1:0] fn_oe,
  output logic [pm_pkg::NPAD-1:0]                      fn_in,
  input  wire logic [pm_pkg::NPAD-1:0]                 pad_in,
  output pm_pkg::pm_pad_drv_s [pm_pkg::NPAD-1:0]       pad_drv,
  output pm_pkg::pm_pad_drv_s                          osc_en_drv,
  output logic [1:0]                                   ant_sel,
  output logic                                         ana_sw_close,
  output logic                                         ext_clk_det
);
  import pm_pkg::*;

  // every register of the block outside the pad cells lives in this one struct, so reset and
  // the next-state copy cover all of it at once
  typedef struct packed {
    pm_padcfg_s [NPAD-1:0] cfg;
    logic                  osc_en;
    logic                  ana_en;
    logic [1:0]            ant;
    logic [NPAD-1:0]       gout;
    logic [NPAD-1:0]       goe;
    pm_boot_e              boot;
    logic [7:0]            sense_cnt;
    logic                  dig_en;
    logic                  ext_clk;
    logic                  ana_sw;
    pm_pad_drv_s           osc_drv;
    logic [1:0]            ant_out;
    pm_apb_rsp_s           rsp;
  } pm_top_s;

  // registered state and its next value
  pm_top_s                          state_r;
  pm_top_s                          state_nxt;
  // pad, decode and bus helper signals
  logic [NPAD-1:0]                  pad_din;
  logic [NPAD-1:0]                  pad_en;
  logic [NPAD-1:0][NMODE-1:0]       sel_out;
  logic [NPAD-1:0][NMODE-1:0]       sel_oe;
  logic [31:0]                      pad_addr [NPAD];
  logic                             setup;
  logic                             wr_take;
  logic [31:0]                      rd_word;
  logic                             hit;
  logic                             ro_wr;

  // byte address of each pad config register, indexed like the pads
  assign pad_addr[PAD_G8]   = PADCFG8_ADDR;
  assign pad_addr[PAD_G9]   = PADCFG9_ADDR;
  assign pad_addr[PAD_ANA]  = PADCFGA_ADDR;
  assign pad_addr[PAD_XTAL] = PADCFGX_ADDR;

  // mode zero takes the gpio data register, others the peripherals
  // the peripheral vectors keep an index 0 slot that is never used;
  // overriding it here keeps each cell a plain mode-indexed selector
  always_comb
  begin
    sel_out = fn_out;
    sel_oe  = fn_oe;
    for (int i = 0; i < NPAD; i++)
    begin
      sel_out[i][MODE_GPIO] = state_r.gout[i];
      sel_oe[i][MODE_GPIO]  = state_r.goe[i];
    end
  end

  // pads open only after start-up; crystal pad only when freed
  // until start-up has run every pad stays released, so board straps
  // and the crystal pad pull-up are not fought by our drivers; a crystal
  // pad without the pull-up keeps its oscillator role until next reset
  always_comb
  begin
    pad_en = {NPAD{state_r.dig_en}};
    pad_en[PAD_XTAL] = state_r.dig_en & state_r.ext_clk;
  end

  // one cell per pad
  // each cell registers its own drive and synchronises its own input,
  // so every pad output and fn_in come straight from a flip-flop
  for (genvar g = 0; g < NPAD; g++)
  begin : g_pad
    pm_pad_cell u_cell (
      .clock  (clock),
      .rst_n  (rst_n),
      .cfg    (state_r.cfg[g]),
      .en     (pad_en[g]),
      .pwr    (pwr_mode),
      .fn_out (sel_out[g]),
      .fn_oe  (sel_oe[g]),
      .pad_in (pad_in[g]),
      .drv    (pad_drv[g]),
      .din    (pad_din[g])
    );
  end

  // apb phase decode
  // zero wait states: pready is registered from the setup cycle, so a
  // write is taken only at the access edge that sees pready high, and a
  // refused access (pslverr) never changes any register
  assign setup   = apb_req.psel & ~apb_req.penable;
  assign wr_take = apb_req.psel & apb_req.penable & state_r.rsp.pready
                   & apb_req.pwrite & ~state_r.rsp.pslverr;

  // read mux and address decode
  // read data are latched at the setup edge and held through access, so
  // moving status bits (pad inputs, power mode) are taken as one snapshot
  // and never torn within a transfer
  always_comb
  begin
    rd_word = 32'h00000000;
    hit     = 1'b0;
    ro_wr   = 1'b0;
    // pad config registers
    for (int i = 0; i < NPAD; i++)
    begin
      if (apb_req.paddr == pad_addr[i])
      begin
        hit = 1'b1;
        rd_word[MODE_LSB +: 4] = state_r.cfg[i].mode;
        rd_word[PU_BIT]        = state_r.cfg[i].pu;
        rd_word[PD_BIT]        = state_r.cfg[i].pd;
      end
    end
    // control, gpio and status words
    if (apb_req.paddr == CTRL_ADDR)
    begin
      hit = 1'b1;
      rd_word[OSC_BIT]      = state_r.osc_en;
      rd_word[ANA_BIT]      = state_r.ana_en;
      rd_word[ANT_LSB +: 2] = state_r.ant;
    end
    if (apb_req.paddr == GPIO_ADDR)
    begin
      hit = 1'b1;
      rd_word[GOUT_LSB +: NPAD] = state_r.gout;
      rd_word[GOE_LSB +: NPAD]  = state_r.goe;
    end
    if (apb_req.paddr == STATUS_ADDR)
    begin
      hit   = 1'b1;
      // status is read-only; a write to it is refused
      ro_wr = apb_req.pwrite;
      rd_word[ST_DIG_BIT]       = state_r.dig_en;
      rd_word[ST_EXT_BIT]       = state_r.ext_clk;
      rd_word[ST_DONE_BIT]      = (state_r.boot == ST_RUN);
      rd_word[ST_IN_LSB +: NPAD] = pad_din;
      rd_word[ST_CONF_BIT]      = state_r.ana_sw & pad_drv[PAD_ANA].oe;
      rd_word[ST_LOW_POWER_DEEP_SLEEP_BIT]      = (pwr_mode == PM_LOW_POWER_DEEP_SLEEP);
      rd_word[ST_HIB_BIT]       = (pwr_mode == PM_HIB);
    end
  end

  // next state: register writes, start-up sequence, pin drives
  always_comb
  begin
    // hold everything unless a part below changes it
    state_nxt = state_r;

    // answer registered in setup, ready for exactly one access cycle
    // prdata and pslverr are cleared once psel drops, so a stale answer
    // cannot be taken for the next one
    state_nxt.rsp.pready = setup;
    if (setup)
    begin
      state_nxt.rsp.prdata  = apb_req.pwrite ? 32'h00000000 : rd_word;
      state_nxt.rsp.pslverr = ~hit | ro_wr;
    end
    else if (!apb_req.psel)
    begin
      state_nxt.rsp.prdata  = 32'h00000000;
      state_nxt.rsp.pslverr = 1'b0;
    end

    // register writes; a write to the status word or to a hole in the
    // map is refused at setup and dropped here
    if (wr_take)
    begin
      // pad config: mode picks the driver, pulls survive deep sleep
      for (int i = 0; i < NPAD; i++)
      begin
        if (apb_req.paddr == pad_addr[i])
        begin
          state_nxt.cfg[i].mode = apb_req.pwdata[MODE_LSB +: 4];
          state_nxt.cfg[i].pu   = apb_req.pwdata[PU_BIT];
          state_nxt.cfg[i].pd   = apb_req.pwdata[PD_BIT];
        end
      end
      // control: oscillator level, analog switch enable, antenna
      if (apb_req.paddr == CTRL_ADDR)
      begin
        state_nxt.osc_en = apb_req.pwdata[OSC_BIT];
        state_nxt.ana_en = apb_req.pwdata[ANA_BIT];
        state_nxt.ant    = apb_req.pwdata[ANT_LSB +: 2];
      end
      // gpio data and output enables, used by pads in mode zero
      if (apb_req.paddr == GPIO_ADDR)
      begin
        state_nxt.gout = apb_req.pwdata[GOUT_LSB +: NPAD];
        state_nxt.goe  = apb_req.pwdata[GOE_LSB +: NPAD];
      end
    end

    // start-up: sense crystal pad pull-up, then open digital path
    // the window waits for the pad synchroniser and the board pull-up to
    // settle; the level seen at its end decides once, until next reset,
    // whether the crystal pad may serve as a digital pad
    case (state_r.boot)
      ST_SENSE:
      begin
        // count the window, then take one look at the crystal pad
        if (state_r.sense_cnt == 8'(SENSE_CYC - 1))
        begin
          state_nxt.ext_clk = pad_din[PAD_XTAL];
          state_nxt.boot    = ST_BOOT;
        end
        else
        begin
          state_nxt.sense_cnt = state_r.sense_cnt + 8'h01;
        end
      end
      ST_BOOT:
      begin
        // hand the pads over to their drivers
        state_nxt.dig_en = 1'b1;
        state_nxt.boot   = ST_RUN;
      end
      ST_RUN:
      begin
        // stays here until the next reset
        state_nxt.boot = ST_RUN;
      end
      default:
      begin
        // an unused code falls back to sensing
        state_nxt.boot = ST_SENSE;
      end
    endcase

    // analog pass switch follows software only, open in hibernate
    // there is no interlock with the shared pad's output enable: software
    // must release the pad first, and a clash is only shown in status;
    // hibernate opens the switch whatever the enable bit holds
    state_nxt.ana_sw = state_r.ana_en & (pwr_mode != PM_HIB);

    // oscillator enable: always an output, floats pulled low in hibernate
    // the pin doubles as a boot strap, so it is never turned into an
    // input; in hibernate it floats and the pulldown keeps the external
    // oscillator off and the strap level low
    if (pwr_mode == PM_HIB)
    begin
      state_nxt.osc_drv.out = 1'b0;
      state_nxt.osc_drv.oe  = 1'b0;
      state_nxt.osc_drv.pd  = 1'b1;
    end
    else
    begin
      state_nxt.osc_drv.out = state_r.osc_en;
      state_nxt.osc_drv.oe  = 1'b1;
      state_nxt.osc_drv.pd  = 1'b0;
    end
    state_nxt.osc_drv.pu  = 1'b0;
    state_nxt.osc_drv.wpd = 1'b0;

    // antenna select pads are dedicated, held through deep sleep
    // deep sleep keeps the last choice so the switch does not flip while
    // the radio sleeps; hibernate releases the pads
    if (pwr_mode == PM_ACTIVE)
      state_nxt.ant_out = state_r.ant;
    else if (pwr_mode == PM_HIB)
      state_nxt.ant_out = 2'b00;
  end

  // state register
  // synchronous reset: the oscillator pin leaves reset already driving
  // high, everything else starts released and cleared
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r             <= '0;
      state_r.osc_en      <= CTRL_RST[OSC_BIT];
      state_r.ana_en      <= CTRL_RST[ANA_BIT];
      state_r.boot        <= ST_SENSE;
      state_r.osc_drv.out <= 1'b1;
      state_r.osc_drv.oe  <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // outputs, each straight from a register
  assign apb_rsp      = state_r.rsp;
  assign fn_in        = pad_din;
  assign osc_en_drv   = state_r.osc_drv;
  assign ant_sel      = state_r.ant_out;
  assign ana_sw_close = state_r.ana_sw;
  assign ext_clk_det  = state_r.ext_clk;

endmodule : pm_pad_mux

// ===== bench/pm_pad_mux_assertions.sv
module pm_pad_mux_chk (
  input wire logic                                  clock,
  input wire logic                                  rst_n,
  input wire pm_pkg::pm_apb_req_s                   apb_req,
  input wire pm_pkg::pm_apb_rsp_s                   apb_rsp,
  input wire pm_pkg::pm_pwr_e                       pwr_mode,
  input wire pm_pkg::pm_pad_drv_s [pm_pkg::NPAD-1:0] pad_drv,
  input wire pm_pkg::pm_pad_drv_s                   osc_en_drv,
  input wire logic [1:0]                            ant_sel,
  input wire logic                                  ana_sw_close
);
  timeunit 1ns;
  timeprecision 1ps;
  import pm_pkg::*;
  logic [NPAD-1:0] wpd_v;
  logic [NPAD-1:0] wpd_oe;
  logic            bad_a;
  logic            ctl_wr;
  // weak pulldown flags and pulldown-while-driving per pad
  always_comb
  begin
    for (int i = 0; i < NPAD; i++)
    begin
      wpd_v[i]  = pad_drv[i].wpd;
      wpd_oe[i] = pad_drv[i].wpd & pad_drv[i].oe;
    end
  end
  // unmapped address and completed control write
  assign bad_a = !(apb_req.paddr inside {PADCFG8_ADDR, PADCFG9_ADDR,
    PADCFGA_ADDR, PADCFGX_ADDR, CTRL_ADDR, GPIO_ADDR, STATUS_ADDR});
  assign ctl_wr = apb_req.psel & apb_req.penable & apb_rsp.pready &
    apb_req.pwrite & (apb_req.paddr == CTRL_ADDR);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_APB_RDY: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not a single cycle after setup");
  AST_APB_ERR: assert property (
    apb_req.psel && !apb_req.penable && (bad_a || (apb_req.pwrite &&
    apb_req.paddr == STATUS_ADDR)) |=> apb_rsp.pslverr)
    else $error("refused access without error");
  AST_HIB_PADS: assert property (
    pwr_mode == PM_HIB |=> pad_drv == '0)
    else $error("pad driven or pulled in hibernate");
  AST_OSC_HIB: assert property (
    pwr_mode == PM_HIB |=> !osc_en_drv.oe && osc_en_drv.pd)
    else $error("oscillator pin not floating low in hibernate");
  AST_OSC_DRV: assert property (
    pwr_mode != PM_HIB |=> osc_en_drv.oe && !osc_en_drv.pd)
    else $error("oscillator pin not an output");
  AST_ANA_HIB: assert property (
    pwr_mode == PM_HIB |=> !ana_sw_close && ant_sel == 2'b00)
    else $error("switch or antenna active in hibernate");
  AST_ANA_ROSE: assert property (
    $rose(ana_sw_close) |-> $past(ctl_wr, 2) &&
    $past(apb_req.pwdata[ANA_BIT], 2))
    else $error("analog switch closed without enable write");
  AST_ANT_WR: assert property (
    ctl_wr && pwr_mode == PM_ACTIVE |-> ##2
    ant_sel == $past(apb_req.pwdata[ANT_LSB+:2], 2))
    else $error("antenna select not following control");
  AST_WPD: assert property (
    |wpd_v |-> wpd_oe == '0 && $past(pwr_mode) == PM_LOW_POWER_DEEP_SLEEP)
    else $error("weak pulldown outside deep sleep or on output");
endmodule : pm_pad_mux_chk

bind pm_pad_mux pm_pad_mux_chk i_pm_pad_mux_chk (
  .clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pwr_mode(pwr_mode), .pad_drv(pad_drv), .osc_en_drv(osc_en_drv),
  .ant_sel(ant_sel), .ana_sw_close(ana_sw_close));

// ===== bench/pm_board.sv
module pm_board (
  input wire logic                                  clock,
  input wire pm_pkg::pm_pad_drv_s [pm_pkg::NPAD-1:0] pad_drv,
  output logic [pm_pkg::NPAD-1:0]                   pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pm_pkg::*;
  logic [NPAD-1:0] lvl = '0;
  // wire level: drive, then pulls, floating pads wander each cycle
  always @(posedge clock)
  begin
    for (int i = 0; i < NPAD; i++)
      if (pad_drv[i].oe)
        lvl[i] <= pad_drv[i].out;
      else if (pad_drv[i].pu || i == PAD_XTAL)
        lvl[i] <= 1'b1; // board pull-up on crystal pad
      else if (pad_drv[i].pd || pad_drv[i].wpd)
        lvl[i] <= 1'b0;
      else
        lvl[i] <= ~lvl[i];
  end
  assign pad_in = lvl;
endmodule : pm_board

// ===== bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pm_pkg::*;
  logic                       clock;
  logic                       rst_n;
  pm_apb_req_s                req;
  pm_apb_rsp_s                rsp;
  pm_pwr_e                    pw;
  logic [NPAD-1:0][NMODE-1:0] fo;
  logic [NPAD-1:0][NMODE-1:0] fe;
  logic [NPAD-1:0]            pin;
  logic [NPAD-1:0]            fin;
  pm_pad_drv_s [NPAD-1:0]     drv;
  pm_pad_drv_s                osc;
  logic [1:0]                 ant;
  logic                       ana;
  logic                       ext;
  logic [31:0]                rdv;
  logic                       err;
  int                         n_mismatch;
  int                         comparisons;

  pm_pad_mux i_pm_pad_mux (.clock(clock), .rst_n(rst_n), .apb_req(req),
    .apb_rsp(rsp), .pwr_mode(pw), .fn_out(fo), .fn_oe(fe), .fn_in(fin),
    .pad_in(pin), .pad_drv(drv), .osc_en_drv(osc), .ant_sel(ant),
    .ana_sw_close(ana), .ext_clk_det(ext));
  pm_board i_pm_board (.clock(clock), .pad_drv(drv), .pad_in(pin));

  // free running clock
  always #10 clock = ~clock;

  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [31:0] a, e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // main sequence
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    pw = PM_ACTIVE;
    fo = '0;
    fe = '0;
    fo[PAD_G9][7] = 1'b1;
    fe[PAD_G9][7] = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    tick(6);
    chk("ana_rst", 32'(ana), 32'h0);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 40 && rdv[ST_DONE_BIT] !== 1'b1; i++)
      apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", rdv & 32'h7, 32'h7);
    chk("ext_det", 32'(ext), 32'h1);
    rd(CTRL_ADDR, CTRL_RST, "ctrl_rst");
    rd(PADCFG8_ADDR, 32'h0, "cfg8_rst");
    chk("osc_rst", 32'(osc), 32'h18);
    rd(32'h4402e0d0, 32'h0, "unmapped");
    chk("unmap_err", 32'(err), 32'h1);
    apb(1'b1, STATUS_ADDR, 32'hffff);
    chk("status_err", 32'(err), 32'h1);
    apb(1'b1, PADCFG8_ADDR, 32'h100);
    apb(1'b1, PADCFG9_ADDR, 32'h7);
    apb(1'b1, PADCFGA_ADDR, 32'h200); // pulldown kept for sleep
    apb(1'b1, GPIO_ADDR, 32'h0909); // crystal pad as output
    rd(PADCFG8_ADDR, 32'h100, "cfg8");
    chk("pad_gpio", 32'(drv[PAD_G8]), 32'h1c);
    chk("pad_fn", 32'(drv[PAD_G9]), 32'h18);
    chk("pad_xtal", 32'(drv[PAD_XTAL]), 32'h18);
    chk("pad_ana", 32'(drv[PAD_ANA]), 32'h02);
    apb(1'b1, CTRL_ADDR, 32'h22); // analog pad output off first
    tick(2);
    chk("ana_on", 32'(ana), 32'h1);
    chk("ant", 32'(ant), 32'h2);
    chk("fn_in", 32'(fin), 32'hb);
    chk("osc_lo", 32'(osc), 32'h08);
    rd(STATUS_ADDR, 32'hb7, "status_run");
    apb(1'b1, GPIO_ADDR, 32'h0d09);
    rd(STATUS_ADDR, 32'h1b7, "conflict");
    apb(1'b1, GPIO_ADDR, 32'h0909); // analog pad released again
    rdv = 32'h0;
    apb(1'b1, PADCFG9_ADDR, 32'h0);
    pw <= PM_LOW_POWER_DEEP_SLEEP;
    tick(3);
    chk("low_power_deep_sleep_used", 32'(drv[PAD_G8]), 32'h1c);
    chk("low_power_deep_sleep_free", 32'(drv[PAD_G9]), 32'h01);
    chk("low_power_deep_sleep_pd", 32'(drv[PAD_ANA]), 32'h02);
    pw <= PM_HIB;
    tick(3);
    for (int i = 0; i < NPAD; i++)
      chk("pad_hib", 32'(drv[i]), 32'h0);
    chk("osc_hib", 32'(osc), 32'h02);
    chk("ana_hib", {ant, 29'h0, ana}, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h1); // strap pin floats until wake, then drives high
    pw <= PM_ACTIVE;
    tick(3);
    chk("osc_wake", 32'(osc), 32'h18);
    finish_test();
  end
endmodule : tb_top
